// >>> rtl/gpp_map.vh
// Register map, field codes and reset values of the parallel I/O ports
`ifndef GPP_MAP_VH
`define GPP_MAP_VH

// Register indexes; the APB byte address is four times the index
`define GPP_IDX_PORT_A_DATA 5'h00
`define GPP_IDX_PORT_A_DIRECTION 5'h01
`define GPP_IDX_PORT_A_OPTION 5'h02
`define GPP_IDX_PORT_C_DATA 5'h04
`define GPP_IDX_PORT_C_DIRECTION 5'h05
`define GPP_IDX_PORT_C_OPTION 5'h06
`define GPP_IDX_PORT_B_DATA 5'h08
`define GPP_IDX_PORT_B_DIRECTION 5'h09
`define GPP_IDX_PORT_B_OPTION 5'h0A
`define GPP_IDX_PORT_E_DATA 5'h0C
`define GPP_IDX_PORT_E_DIRECTION 5'h0D
`define GPP_IDX_PORT_E_OPTION 5'h0E
`define GPP_IDX_PORT_D_DATA 5'h10
`define GPP_IDX_PORT_D_DIRECTION 5'h11
`define GPP_IDX_PORT_D_OPTION 5'h12
`define GPP_IDX_PORT_F_DATA 5'h14
`define GPP_IDX_PORT_F_DIRECTION 5'h15
`define GPP_IDX_PORT_F_OPTION 5'h16

// Index fields: port block number and register within the block
`define GPP_IDX_PORT_MSB 4
`define GPP_IDX_PORT_LSB 2
`define GPP_IDX_REG_MSB 1
`define GPP_IDX_REG_LSB 0
`define GPP_NUM_PORTS 3'h6
`define GPP_REG_DATA 2'h0
`define GPP_REG_DIRECTION 2'h1
`define GPP_REG_OPTION 2'h2

// Reset values
`define GPP_RST_DATA 8'h00
`define GPP_RST_DIRECTION 8'h00
`define GPP_RST_OPTION 8'h00

// Interrupt sensitivity codes
`define GPP_SENS_FALL_LOW 2'h0
`define GPP_SENS_RISE 2'h1
`define GPP_SENS_FALL 2'h2
`define GPP_SENS_BOTH 2'h3

`endif

// >>> rtl/gpp_port.v
// Six 8-bit parallel I/O ports with APB registers and external interrupts
`timescale 1ns/100ps
// What this block does
// - Input pin with alternate output enabled reads back the alternate output.
// - Output pin with alternate input feeds the peripheral from the data latch.
// - Standard pin: direction/option 00 float, 01 pull-up, 10 drain, 11 push.
// - Pulled interrupt pin: direction 0 option 1 is pull-up interrupt input.
// - Unpulled interrupt pin: 01 is floating interrupt input, never pull-up.
// - True open-drain pin: direction alone, input or sink; no pull-up or push.
// - Low-power states change no port state; enabled interrupts wake.
// - Requests only from interrupt-mode pins; CPU takes them while unmasked.
// - Data writes always update the latch, even for input pins.
// - Data read gives latch for outputs and synced pin level for inputs.
// - Direction bits: 0 input, 1 output, each bit readable and writable.
// - In input mode option 0 is floating, option 1 is pull-up.
// - In output mode option 0 is open drain, option 1 is push-pull.
// - Ports without option register are configured by direction alone.
// - Reset clears data, direction and option registers of every port.
// - Each port has three consecutive registers, blocks four apart.
// - Bit n of each register belongs to pin n of its port.
// - Enabled pins sharing one vector are NANDed; a low pin masks others.
// - Bits of absent pins read as 1.
`include "gpp_map.vh"

module gpp_port #(
    parameter ADDR_W = 8,
    // Pin n of port p is bit 8*p+n; ports in address order A,C,B,E,D,F
    parameter [47:0] PRESENT = 48'hD7FFF3FFFFFF,
    parameter [47:0] IRQ_PULLED = 48'h030000E70007,
    parameter [47:0] IRQ_FLOAT = 48'h040000180008,
    parameter [47:0] TRUE_OD = 48'h0000000000C0,
    parameter [5:0] HAS_OPTION = 6'h3F,
    parameter [47:0] GROUP0 = 48'h00000000000F,
    parameter [47:0] GROUP1 = 48'h070000000000,
    parameter [47:0] GROUP2 = 48'h0000000F0000,
    parameter [47:0] GROUP3 = 48'h000000F00000
) (
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [47:0] pin_in,
    output reg [47:0] pin_out,
    output reg [47:0] pin_oe,
    output reg [47:0] pin_pu_en,
    input wire [47:0] af_out_en,
    input wire [47:0] af_out,
    input wire [47:0] af_od,
    output reg [47:0] af_in,
    input wire [1:0] sens_grp01,
    input wire [1:0] sens_grp23,
    input wire int_mask,
    input wire [3:0] irq_ack,
    output reg [3:0] ext_req,
    output wire cpu_irq,
    output wire wake
);

    reg [47:0] data_latch;
    reg [47:0] direction_bits;
    reg [47:0] option_bits;
    reg [47:0] pin_meta;
    reg [47:0] pin_sync;
    reg [3:0] line_q;

    reg [47:0] opt_eff;
    reg [47:0] out_mode;
    reg [47:0] irq_en;
    reg [47:0] rd_bits;
    reg [47:0] next_pin_out;
    reg [47:0] next_pin_oe;
    reg [47:0] next_pin_pu_en;
    reg [47:0] next_af_in;
    reg [3:0] line_now;
    reg [3:0] evt;
    reg [7:0] rd_byte;
    reg push;
    integer i;

    wire [4:0] idx;
    wire [2:0] port_sel;
    wire [1:0] reg_sel;
    wire hi_zero;
    wire mapped;
    wire wr_en;
    wire [5:0] bit_base;

    // Event detector for one interrupt line
    function ev_hit;
        input [1:0] sens;
        input prev;
        input cur;
        begin
            case (sens)
                `GPP_SENS_FALL_LOW: ev_hit = ~cur;
                `GPP_SENS_RISE: ev_hit = ~prev & cur;
                `GPP_SENS_FALL: ev_hit = prev & ~cur;
                default: ev_hit = prev ^ cur;
            endcase
        end
    endfunction

    // AND of enabled pin levels; its NAND is the request line
    function grp_line;
        input [47:0] mask;
        input [47:0] en;
        input [47:0] lvl;
        begin
            grp_line = &(lvl | ~(mask & en));
        end
    endfunction

    // Eight bits of one port out of a 48-bit vector
    function [7:0] port_bits;
        input [47:0] v;
        input [2:0] p;
        begin
            case (p)
                3'h0: port_bits = v[7:0];
                3'h1: port_bits = v[15:8];
                3'h2: port_bits = v[23:16];
                3'h3: port_bits = v[31:24];
                3'h4: port_bits = v[39:32];
                default: port_bits = v[47:40];
            endcase
        end
    endfunction

    // Address decode: index = byte address / 4
    assign idx = paddr[6:2];
    assign port_sel = idx[`GPP_IDX_PORT_MSB:`GPP_IDX_PORT_LSB];
    assign reg_sel = idx[`GPP_IDX_REG_MSB:`GPP_IDX_REG_LSB];
    generate
        if (ADDR_W > 7) begin : g_hi
            assign hi_zero = ~|paddr[ADDR_W-1:7];
        end else begin : g_nohi
            assign hi_zero = 1'b1;
        end
    endgenerate
    assign mapped = hi_zero && (paddr[1:0] == 2'h0) &&
        (port_sel < `GPP_NUM_PORTS) && (reg_sel != 2'h3);
    assign bit_base = {port_sel, 3'h0};

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en = psel & penable & pwrite & mapped & pstrb[0];

    // Synchroniser: first stage feeds only the second
    always @(posedge sys_clk) begin
        if (rst) begin
            pin_meta <= 48'h000000000000;
            pin_sync <= 48'h000000000000;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Per-pin mode decode
    always @* begin
        opt_eff = 48'h000000000000;
        out_mode = 48'h000000000000;
        irq_en = 48'h000000000000;
        rd_bits = 48'h000000000000;
        next_pin_out = 48'h000000000000;
        next_pin_oe = 48'h000000000000;
        next_pin_pu_en = 48'h000000000000;
        next_af_in = 48'h000000000000;
        push = 1'b0;
        for (i = 0; i < 48; i = i + 1) begin
            // No option register or true open drain: direction alone
            opt_eff[i] = option_bits[i] & HAS_OPTION[i/8] &
                ~TRUE_OD[i];
            // Peripheral output takes priority over port programming
            out_mode[i] = direction_bits[i] | af_out_en[i];
            irq_en[i] = ~direction_bits[i] & opt_eff[i] &
                (IRQ_PULLED[i] | IRQ_FLOAT[i]);
            if (af_out_en[i]) begin
                push = ~af_od[i] & ~TRUE_OD[i];
                next_pin_out[i] = af_out[i];
            end else begin
                push = opt_eff[i];
                next_pin_out[i] = data_latch[i];
            end
            if (out_mode[i] && PRESENT[i]) begin
                next_pin_oe[i] = push | ~next_pin_out[i];
            end
            next_pin_pu_en[i] = ~out_mode[i] & opt_eff[i] &
                ~IRQ_FLOAT[i] & PRESENT[i];
            if (direction_bits[i]) begin
                rd_bits[i] = data_latch[i];
                next_af_in[i] = data_latch[i];
            end else begin
                rd_bits[i] = af_out_en[i] ? af_out[i] :
                    pin_sync[i];
                next_af_in[i] = pin_sync[i];
            end
        end
    end

    // Read mux; absent pins read as 1
    always @* begin
        case (reg_sel)
            `GPP_REG_DATA: rd_byte = port_bits(rd_bits, port_sel);
            `GPP_REG_DIRECTION: rd_byte = port_bits(direction_bits,
                port_sel);
            default: rd_byte = port_bits(opt_eff, port_sel);
        endcase
        rd_byte = rd_byte | ~port_bits(PRESENT, port_sel);
        if (!mapped) begin
            rd_byte = 8'h00;
        end
    end

    // Register file
    always @(posedge sys_clk) begin
        if (rst) begin
            data_latch <= {6{`GPP_RST_DATA}};
            direction_bits <= {6{`GPP_RST_DIRECTION}};
            option_bits <= {6{`GPP_RST_OPTION}};
            prdata <= 32'h00000000;
        end else begin
            if (psel && !penable && !pwrite) begin
                prdata <= {24'h000000, rd_byte};
            end
            if (wr_en) begin
                // Latch written whatever the direction
                case (reg_sel)
                    `GPP_REG_DATA: data_latch[bit_base +: 8] <=
                        pwdata[7:0];
                    `GPP_REG_DIRECTION: direction_bits[bit_base +: 8] <=
                        pwdata[7:0];
                    default: option_bits[bit_base +: 8] <=
                        pwdata[7:0];
                endcase
            end
        end
    end

    // Registered pin and peripheral drive; wait/halt leave it untouched
    always @(posedge sys_clk) begin
        if (rst) begin
            pin_out <= 48'h000000000000;
            pin_oe <= 48'h000000000000;
            pin_pu_en <= 48'h000000000000;
            af_in <= 48'h000000000000;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            pin_pu_en <= next_pin_pu_en & ~TRUE_OD;
            af_in <= next_af_in;
        end
    end

    // Interrupt lines: enabled pins combined, then edge/level detect
    always @* begin
        line_now[0] = grp_line(GROUP0, irq_en, pin_sync);
        line_now[1] = grp_line(GROUP1, irq_en, pin_sync);
        line_now[2] = grp_line(GROUP2, irq_en, pin_sync);
        line_now[3] = grp_line(GROUP3, irq_en, pin_sync);
        evt[0] = ev_hit(sens_grp01, line_q[0], line_now[0]);
        evt[1] = ev_hit(sens_grp01, line_q[1], line_now[1]);
        evt[2] = ev_hit(sens_grp23, line_q[2], line_now[2]);
        evt[3] = ev_hit(sens_grp23, line_q[3], line_now[3]);
    end

    // Request latch, cleared by vector fetch; a new event beats the clear
    always @(posedge sys_clk) begin
        if (rst) begin
            line_q <= 4'hF;
            ext_req <= 4'h0;
        end else begin
            line_q <= line_now;
            ext_req <= (ext_req & ~irq_ack) | evt;
        end
    end

    // Mask gates only the CPU take; wake sees every pending request
    assign cpu_irq = |ext_req & ~int_mask;
    assign wake = |ext_req;

endmodule

// >>> dv/gpp_port_checker.sv
// Port-level assertions for the parallel I/O ports
`timescale 1ns/100ps
module gpp_port_checker #(
    parameter ADDR_W = 8
) (
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire [ADDR_W-1:0] paddr,
    input wire pslverr,
    input wire [47:0] pin_out,
    input wire [47:0] pin_oe,
    input wire [47:0] pin_pu_en,
    input wire int_mask,
    input wire [3:0] irq_ack,
    input wire [3:0] ext_req,
    input wire cpu_irq,
    input wire wake
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_rst_idle;
        $past(rst) |-> !pin_oe && !pin_pu_en && !ext_req;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("pins or requests active after reset");
    property p_tod;
        !pin_pu_en[7:6] && !(pin_oe[7:6] & pin_out[7:6]);
    endproperty
    a_tod: assert property (p_tod)
        else $error("true open drain pin pulled or driven high");
    property p_float_irq;
        !(pin_pu_en & 48'h040000180008);
    endproperty
    a_float_irq: assert property (p_float_irq)
        else $error("pull-up on a pin without pull-up");
    property p_pull_in;
        !(pin_pu_en & pin_oe);
    endproperty
    a_pull_in: assert property (p_pull_in)
        else $error("pull-up on a driven pin");
    property p_irq_mask;
        cpu_irq == ((|ext_req) && !int_mask);
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("cpu request disagrees with mask");
    property p_wake;
        (|ext_req) |-> wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("pending request without wake");
    property p_unmapped;
        psel && penable && paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unaligned access not refused");
    property p_req_hold;
        ext_req[0] && !irq_ack[0] |=> ext_req[0];
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped without acknowledge");
endmodule

bind gpp_port gpp_port_checker #(.ADDR_W(ADDR_W)) u_gpp_port_checker (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pu_en(pin_pu_en), .int_mask(int_mask),
    .irq_ack(irq_ack), .ext_req(ext_req), .cpu_irq(cpu_irq), .wake(wake)
);

// >>> dv/gpp_pins_model.sv
// Pads: port drive, pull-ups and outside sources
`timescale 1ns/100ps
module gpp_pins_model (
    input wire sys_clk,
    input wire [47:0] pin_out,
    input wire [47:0] pin_oe,
    input wire [47:0] pin_pu_en,
    input wire [47:0] ext_lvl,
    input wire [47:0] ext_en,
    output logic [47:0] pin_in
);
    logic noise = 1'b0;
    // A released pin wanders so a stale level never passes as valid
    always @(posedge sys_clk) noise <= ~noise;
    always_comb begin
        for (int i = 0; i < 48; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_lvl[i];
            else if (pin_pu_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = noise;
        end
    end
endmodule

// >>> dv/gpp_port_tb_top.sv
// Self-checking bench for the parallel I/O ports
`timescale 1ns/100ps
module gpp_port_tb_top;
    localparam [47:0] ABSENT = 48'h28000C000000;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, rd;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, cpu_irq, wake, err, int_mask = 1;
    logic [47:0] pin_in, pin_out, pin_oe, pin_pu_en, af_in;
    logic [47:0] af_out_en = 48'h0, af_out = 48'h0;
    logic [47:0] ext_lvl = 48'h3C3C3C3C3C3C, ext_en = ~48'h0;
    logic [1:0] sens_grp01 = 2'h0;
    logic [3:0] irq_ack = 4'h0, ext_req;
    int n_fail = 0, total_checks = 0, cyc = 0;
    gpp_port u_gpp_port (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pu_en(pin_pu_en), .af_out_en(af_out_en),
        .af_out(af_out), .af_od(48'h0), .af_in(af_in),
        .sens_grp01(sens_grp01), .sens_grp23(2'h2), .int_mask(int_mask),
        .irq_ack(irq_ack), .ext_req(ext_req), .cpu_irq(cpu_irq),
        .wake(wake));
    gpp_pins_model u_gpp_pins_model (.sys_clk(sys_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pu_en(pin_pu_en), .ext_lvl(ext_lvl),
        .ext_en(ext_en), .pin_in(pin_in));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task print_verdict;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task chk(input logic [47:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Holds the request until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, d);
        @(posedge sys_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task rdchk(input logic [7:0] a, e);
        apb(1'b0, a, 8'h00);
        chk({40'h0, rd}, {40'h0, e});
    endtask
    function logic [7:0] ad(input int p, r);
        return {1'b0, p[2:0], r[1:0], 2'b00};
    endfunction
    function logic [7:0] ab(input int p);
        return ABSENT[8*p+:8];
    endfunction
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 0;
        repeat (3) @(posedge sys_clk);
        for (int p = 0; p < 6; p++) begin
            rdchk(ad(p, 0), 8'h3C | ab(p));
            rdchk(ad(p, 1), ab(p));
            rdchk(ad(p, 2), ab(p));
            apb(1'b1, ad(p, 0), 8'h96);
            apb(1'b1, ad(p, 1), 8'hF0);
            rdchk(ad(p, 0), 8'h9C | ab(p));
            rdchk(ad(p, 1), 8'hF0 | ab(p));
            chk(pin_oe[8*p+:8], 8'h60 & ~ab(p));
        end
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ad(1, 1), m[1] ? 8'hFF : 8'h00);
            apb(1'b1, ad(1, 2), m[0] ? 8'hFF : 8'h00);
            apb(1'b1, ad(1, 0), 8'h55);
            rdchk(ad(1, 2), m[0] ? 8'hFF : 8'h00);
            chk({pin_pu_en[15:8], pin_oe[15:8]}, {m == 1 ? 8'hFF : 8'h00,
                m[1] ? (m[0] ? 8'hFF : 8'hAA) : 8'h00});
        end
        apb(1'b1, ad(0, 1), 8'hC0);
        apb(1'b1, ad(0, 2), 8'hF0);
        apb(1'b1, ad(0, 0), 8'h40);
        rdchk(ad(0, 2), 8'h30);
        chk({pin_pu_en[7:0], pin_oe[7:0]}, 16'h3080);
        // Peripheral tests stay on port D, which has no interrupt pins
        apb(1'b1, ad(4, 1), 8'h00);
        af_out_en[39:32] <= 8'hFF;
        af_out[39:32] <= 8'h69;
        rdchk(ad(4, 0), 8'h69);
        af_out_en <= 48'h0;
        apb(1'b1, ad(4, 1), 8'hFF);
        repeat (2) @(posedge sys_clk);
        chk(af_in[39:32], 8'h96);
        sens_grp01 <= 2'h2;
        ext_lvl[3:0] <= 4'hF;
        repeat (4) @(posedge sys_clk);
        apb(1'b1, ad(0, 2), 8'h03);
        repeat (4) @(posedge sys_clk);
        chk(ext_req, 4'h0);
        ext_lvl[1] <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk({wake, cpu_irq, ext_req}, 6'h21);
        irq_ack <= 4'h1;
        @(posedge sys_clk);
        irq_ack <= 4'h0;
        ext_lvl[0] <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk(ext_req, 4'h0);
        int_mask <= 0;
        ext_lvl[1:0] <= 2'h3;
        repeat (5) @(posedge sys_clk);
        ext_lvl[0] <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk({cpu_irq, ext_req}, 5'h11);
        apb(1'b1, ad(2, 1), 8'h00);
        repeat (2) @(posedge sys_clk);
        chk({pin_pu_en[23:16], pin_oe[23:16]}, 16'h0000);
        // B7..4 enabled while B7..6 sit low: enabling gives a fall
        apb(1'b1, ad(2, 2), 8'hF0);
        repeat (3) @(posedge sys_clk);
        chk({pin_pu_en[23:16], ext_req}, {8'hE0, 4'h9});
        foreach (ABSENT[i]) if (i < 3) begin
            apb(1'b0, i == 0 ? 8'h01 : (i == 1 ? 8'h0C : 8'h60), 8'h00);
            chk({err, rd}, 9'h100);
        end
        print_verdict();
    end
endmodule
